// [verilog/rstso_defines.vh]
`ifndef RSTSO_DEFINES_VH
`define RSTSO_DEFINES_VH

// ----------------------------------------------------------------
// Register indices on the register select port
// ----------------------------------------------------------------
`define RSTSO_IDX_CAUSE		2'h0
`define RSTSO_IDX_FORCE		2'h1
`define RSTSO_IDX_OPT1		2'h2

// ----------------------------------------------------------------
// Reset cause flag positions
// ----------------------------------------------------------------
`define RSTSO_F_POR		7
`define RSTSO_F_PIN		6
`define RSTSO_F_WDOG		5
`define RSTSO_F_ILLEGAL_OPCODE_FLAG		4
`define RSTSO_F_ILLEGAL_ADDRESS_FLAG		3
`define RSTSO_F_LVD		1
`define RSTSO_CAUSE_POR		8'h82

// ----------------------------------------------------------------
// System options one fields
// ----------------------------------------------------------------
`define RSTSO_O_TSEL_HI		7
`define RSTSO_O_TSEL_LO		6
`define RSTSO_O_STOP		5
`define RSTSO_O_RSVD		4
`define RSTSO_O_I2C		2
`define RSTSO_OPT1_MASK		8'hF4
`define RSTSO_OPT1_RST		8'hC0
`define RSTSO_FORCE_BIT		0
`define RSTSO_READ_ZERO		8'h00

// ----------------------------------------------------------------
// Watchdog service values and periods
// ----------------------------------------------------------------
`define RSTSO_WD_KEY1		8'h55
`define RSTSO_WD_KEY2		8'hAA
`define RSTSO_WD_TICK1		19'h00020
`define RSTSO_WD_TICK2		19'h00100
`define RSTSO_WD_TICK3		19'h00400
`define RSTSO_WD_BUS1		19'h02000
`define RSTSO_WD_BUS2		19'h10000
`define RSTSO_WD_BUS3		19'h40000

// ----------------------------------------------------------------
// Reset hold timing
// ----------------------------------------------------------------
`define RSTSO_CLK_MHZ		200
`define RSTSO_HOLD_NS		100
`define RSTSO_HOLD_CYC		((`RSTSO_HOLD_NS * `RSTSO_CLK_MHZ + 999) / 1000)
`define RSTSO_SYNC_INIT		6'h3D

`endif

// [verilog/rstso_wdog.v]
`timescale 1ns/100ps
`include "rstso_defines.vh"

module rstso_wdog #(
	parameter [18:0]	BUS_LEN1 = `RSTSO_WD_BUS1,
	parameter [18:0]	BUS_LEN2 = `RSTSO_WD_BUS2,
	parameter [18:0]	BUS_LEN3 = `RSTSO_WD_BUS3
) (
	input  wire		clk_sys_i,
	input  wire		reset_n_i,
	input  wire		ce_i,
	input  wire		clear_i,
	input  wire		tick_i,
	input  wire		clk_sel_i,
	input  wire		window_i,
	input  wire [1:0]	tsel_i,
	input  wire		wr_i,
	input  wire [7:0]	wdata_i,
	output reg		trip_o
);

	reg  [18:0]	cnt_ff;
	reg		armed_ff;
	reg  [18:0]	period;

	always @* begin
		case ({clk_sel_i, tsel_i})
		3'h1:	period = `RSTSO_WD_TICK1;
		3'h2:	period = `RSTSO_WD_TICK2;
		3'h3:	period = `RSTSO_WD_TICK3;
		3'h5:	period = BUS_LEN1;
		3'h6:	period = BUS_LEN2;
		3'h7:	period = BUS_LEN3;
		default:	period = 19'h00000;
		endcase
	end

	wire		enabled = |tsel_i;
	wire [18:0]	win_lim = period - (period >> 2);
	wire		key1 = (wdata_i == `RSTSO_WD_KEY1);
	wire		key2 = (wdata_i == `RSTSO_WD_KEY2);
	// Window only exists on the bus clock source
	wire		early = wr_i & window_i & clk_sel_i & (cnt_ff < win_lim);
	wire		bad = wr_i & ~key1 & ~key2;
	wire		service = wr_i & key2 & armed_ff;
	wire		adv = clk_sel_i | tick_i;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_ff <= 19'h00000;
			armed_ff <= 1'b0;
			trip_o <= 1'b0;
		end else if (ce_i) begin
			if (clear_i) begin
				cnt_ff <= 19'h00000;
				armed_ff <= 1'b0;
				trip_o <= 1'b0;
			end else begin
				trip_o <= 1'b0;
				if (wr_i)
					armed_ff <= key1;
				if (enabled) begin
					if (bad | early) begin
						trip_o <= 1'b1;
					end else if (service) begin
						cnt_ff <= 19'h00000;
					end else if (adv) begin
						if (cnt_ff == period - 19'h00001) begin
							trip_o <= 1'b1;
							cnt_ff <= 19'h00000;
						end else begin
							cnt_ff <= cnt_ff + 19'h00001;
						end
					end
				end
			end
		end
	end

endmodule

// [verilog/rstso_top.v]
`timescale 1ns/100ps
`include "rstso_defines.vh"

module rstso_top #(
	parameter [18:0]	WD_BUS_LEN1 = `RSTSO_WD_BUS1,
	parameter [18:0]	WD_BUS_LEN2 = `RSTSO_WD_BUS2,
	parameter [18:0]	WD_BUS_LEN3 = `RSTSO_WD_BUS3
) (
	input  wire		clk_sys_i,
	input  wire		reset_n_i,
	input  wire		ce_i,
	input  wire [1:0]	reg_sel_i,
	input  wire		reg_wr_i,
	input  wire		reg_rd_i,
	input  wire [7:0]	reg_wdata_i,
	output reg  [7:0]	reg_rdata_o,
	input  wire		bdm_wr_i,
	input  wire [1:0]	bdm_sel_i,
	input  wire [7:0]	bdm_wdata_i,
	input  wire		pin_reset_n_i,
	input  wire		lvd_trip_i,
	input  wire		low_voltage_reset_enable_i,
	input  wire		illegal_opcode_i,
	input  wire		illegal_address_i,
	input  wire		stop_exec_i,
	input  wire		background_instruction_exec_i,
	input  wire		background_mode_enable_i,
	input  wire		watchdog_clock_select_i,
	input  wire		watchdog_window_i,
	input  wire		wdog_tick_i,
	input  wire		i2c_sda_drv_i,
	input  wire		i2c_sda_oe_i,
	input  wire		i2c_scl_drv_i,
	input  wire		i2c_scl_oe_i,
	input  wire		pta2_i,
	input  wire		pta3_i,
	input  wire		ptb6_i,
	input  wire		ptb7_i,
	output reg		mcu_reset_o,
	output reg		stop_permission_o,
	output reg  [1:0]	watchdog_timeout_select_o,
	output reg		i2c_location_select_o,
	output reg		i2c_sda_in_o,
	output reg		i2c_scl_in_o,
	output reg		pta2_o,
	output reg		pta2_oe_o,
	output reg		pta3_o,
	output reg		pta3_oe_o,
	output reg		ptb6_o,
	output reg		ptb6_oe_o,
	output reg		ptb7_o,
	output reg		ptb7_oe_o
);

	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam		ST_RUN = 1'b0;
	localparam		ST_HOLD = 1'b1;
	localparam [31:0]	HOLD_CYC_W = `RSTSO_HOLD_CYC;
	localparam [7:0]	HOLD_CYC = HOLD_CYC_W[7:0];
	localparam [5:0]	SYNC_INIT = `RSTSO_SYNC_INIT;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// A change counts only once stages two and three agree, so a
	// single-cycle glitch past the first stage is filtered out.
	wire [5:0]	async_in;
	wire [5:0]	pin_f;

	assign async_in = {ptb7_i, ptb6_i, pta3_i, pta2_i, lvd_trip_i, pin_reset_n_i};

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_sync
			reg	s1_ff;
			reg	s2_ff;
			reg	s3_ff;
			reg	flt_ff;

			always @(posedge clk_sys_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					s1_ff <= SYNC_INIT[g];
					s2_ff <= SYNC_INIT[g];
					s3_ff <= SYNC_INIT[g];
					flt_ff <= SYNC_INIT[g];
				end else if (ce_i) begin
					s1_ff <= async_in[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff)
						flt_ff <= s3_ff;
				end
			end

			assign pin_f[g] = flt_ff;
		end
	endgenerate

	wire		pin_low = ~pin_f[0];
	wire		lvd_low = pin_f[1];
	wire		pta2_f = pin_f[2];
	wire		pta3_f = pin_f[3];
	wire		ptb6_f = pin_f[4];
	wire		ptb7_f = pin_f[5];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg		state_ff;
	reg  [7:0]	hold_cnt_ff;
	reg  [7:0]	cause_ff;
	reg  [7:0]	opt1_ff;
	reg		opt1_lock_ff;
	wire		wdog_trip;

	wire		in_run = (state_ff == ST_RUN);
	wire		sel_cause = (reg_sel_i == `RSTSO_IDX_CAUSE);
	wire		sel_force = (reg_sel_i == `RSTSO_IDX_FORCE);
	wire		sel_opt1 = (reg_sel_i == `RSTSO_IDX_OPT1);

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	wire		stop_perm = opt1_ff[`RSTSO_O_STOP];
	wire		src_pin = pin_low;
	wire		src_lvr = lvd_low & low_voltage_reset_enable_i;
	wire		src_wdog = wdog_trip;
	wire		src_illegal_opcode_flag = illegal_opcode_i
				| (stop_exec_i & ~stop_perm)
				| (background_instruction_exec_i & ~background_mode_enable_i);
	wire		src_illegal_address_flag = illegal_address_i;
	// Only the background port reaches the force bit
	wire		src_dbg = bdm_wr_i & (bdm_sel_i == `RSTSO_IDX_FORCE)
				& bdm_wdata_i[`RSTSO_FORCE_BIT];
	wire		any_src = src_pin | src_lvr | src_wdog | src_illegal_opcode_flag
				| src_illegal_address_flag | src_dbg;

	// ----------------------------------------------------------------
	// Reset cause capture
	// ----------------------------------------------------------------
	reg  [7:0]	nxt_cause;

	always @* begin
		nxt_cause = 8'h00;
		// Power-on flag survives only a low-voltage reset
		nxt_cause[`RSTSO_F_POR] = src_lvr & cause_ff[`RSTSO_F_POR];
		nxt_cause[`RSTSO_F_PIN] = src_pin;
		nxt_cause[`RSTSO_F_WDOG] = src_wdog;
		nxt_cause[`RSTSO_F_ILLEGAL_OPCODE_FLAG] = src_illegal_opcode_flag;
		nxt_cause[`RSTSO_F_ILLEGAL_ADDRESS_FLAG] = src_illegal_address_flag;
		nxt_cause[`RSTSO_F_LVD] = src_lvr;
		if (src_dbg)
			nxt_cause = 8'h00;
	end

	// Flags move only on reset entry, never on a register write
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cause_ff <= `RSTSO_CAUSE_POR;
		end else if (ce_i) begin
			if (in_run && any_src)
				cause_ff <= nxt_cause & 8'hFA;
		end
	end

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	// Hold time is a floor; an active pin or enabled low-voltage
	// condition keeps the controller in reset past it.
	reg		nxt_state;
	reg  [7:0]	nxt_hold_cnt;

	always @* begin
		nxt_state = state_ff;
		nxt_hold_cnt = hold_cnt_ff;
		case (state_ff)
		ST_RUN: begin
			if (any_src) begin
				nxt_state = ST_HOLD;
				nxt_hold_cnt = 8'h00;
			end
		end
		ST_HOLD: begin
			if (hold_cnt_ff != HOLD_CYC)
				nxt_hold_cnt = hold_cnt_ff + 8'h01;
			else if (!pin_low && !src_lvr)
				nxt_state = ST_RUN;
		end
		default: begin
			nxt_state = ST_HOLD;
			nxt_hold_cnt = 8'h00;
		end
		endcase
	end

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_HOLD;
			hold_cnt_ff <= 8'h00;
			mcu_reset_o <= 1'b1;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			hold_cnt_ff <= nxt_hold_cnt;
			mcu_reset_o <= (nxt_state == ST_HOLD);
		end
	end

	// ----------------------------------------------------------------
	// System options one, write once
	// ----------------------------------------------------------------
	// Lock clears with every controller reset, so each reset allows
	// exactly one configuring write.
	wire		opt1_wr = in_run & reg_wr_i & sel_opt1;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			opt1_ff <= `RSTSO_OPT1_RST;
			opt1_lock_ff <= 1'b0;
		end else if (ce_i) begin
			if (!in_run) begin
				opt1_ff <= `RSTSO_OPT1_RST;
				opt1_lock_ff <= 1'b0;
			end else if (opt1_wr && !opt1_lock_ff) begin
				opt1_ff <= reg_wdata_i & `RSTSO_OPT1_MASK;
				opt1_lock_ff <= 1'b1;
			end
		end
	end

	// Reserved bit 4 is kept for read-back only
	wire [1:0]	wd_tsel = opt1_ff[`RSTSO_O_TSEL_HI:`RSTSO_O_TSEL_LO];
	wire		i2c_alt = opt1_ff[`RSTSO_O_I2C];

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	wire		cause_wr = in_run & reg_wr_i & sel_cause;

	rstso_wdog #(
		.BUS_LEN1	(WD_BUS_LEN1),
		.BUS_LEN2	(WD_BUS_LEN2),
		.BUS_LEN3	(WD_BUS_LEN3)
	) u_wdog (
		.clk_sys_i	(clk_sys_i),
		.reset_n_i	(reset_n_i),
		.ce_i		(ce_i),
		.clear_i	(~in_run),
		.tick_i		(wdog_tick_i),
		.clk_sel_i	(watchdog_clock_select_i),
		.window_i	(watchdog_window_i),
		.tsel_i		(wd_tsel),
		.wr_i		(cause_wr),
		.wdata_i	(reg_wdata_i),
		.trip_o		(wdog_trip)
	);

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= `RSTSO_READ_ZERO;
		end else if (ce_i) begin
			if (reg_rd_i) begin
				if (sel_cause)
					reg_rdata_o <= cause_ff & 8'hFA;
				else if (sel_force)
					reg_rdata_o <= `RSTSO_READ_ZERO;
				else if (sel_opt1)
					reg_rdata_o <= opt1_ff;
				else
					reg_rdata_o <= `RSTSO_READ_ZERO;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stop_permission_o <= 1'b0;
			watchdog_timeout_select_o <= 2'h3;
			i2c_location_select_o <= 1'b0;
		end else if (ce_i) begin
			stop_permission_o <= stop_perm;
			watchdog_timeout_select_o <= wd_tsel;
			i2c_location_select_o <= i2c_alt;
		end
	end

	// ----------------------------------------------------------------
	// I2C pin routing
	// ----------------------------------------------------------------
	// Registered routing adds one cycle each way; harmless against
	// I2C bit rates but the unused pair is released at once.
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pta2_o <= 1'b0;
			pta2_oe_o <= 1'b0;
			pta3_o <= 1'b0;
			pta3_oe_o <= 1'b0;
			ptb6_o <= 1'b0;
			ptb6_oe_o <= 1'b0;
			ptb7_o <= 1'b0;
			ptb7_oe_o <= 1'b0;
			i2c_sda_in_o <= 1'b1;
			i2c_scl_in_o <= 1'b1;
		end else if (ce_i) begin
			if (i2c_alt) begin
				pta2_o <= 1'b0;
				pta2_oe_o <= 1'b0;
				pta3_o <= 1'b0;
				pta3_oe_o <= 1'b0;
				ptb6_o <= i2c_sda_drv_i;
				ptb6_oe_o <= i2c_sda_oe_i & in_run;
				ptb7_o <= i2c_scl_drv_i;
				ptb7_oe_o <= i2c_scl_oe_i & in_run;
				i2c_sda_in_o <= ptb6_f;
				i2c_scl_in_o <= ptb7_f;
			end else begin
				pta2_o <= i2c_sda_drv_i;
				pta2_oe_o <= i2c_sda_oe_i & in_run;
				pta3_o <= i2c_scl_drv_i;
				pta3_oe_o <= i2c_scl_oe_i & in_run;
				ptb6_o <= 1'b0;
				ptb6_oe_o <= 1'b0;
				ptb7_o <= 1'b0;
				ptb7_oe_o <= 1'b0;
				i2c_sda_in_o <= pta2_f;
				i2c_scl_in_o <= pta3_f;
			end
		end
	end

endmodule

// [bench/rstso_properties.sv]
`timescale 1ns/100ps
module rstso_props (
	input wire		clk_sys_i,
	input wire		reset_n_i,
	input wire		ce_i,
	input wire [1:0]	reg_sel_i,
	input wire		reg_wr_i,
	input wire		reg_rd_i,
	input wire [7:0]	reg_wdata_i,
	input wire [7:0]	reg_rdata_o,
	input wire		bdm_wr_i,
	input wire [1:0]	bdm_sel_i,
	input wire [7:0]	bdm_wdata_i,
	input wire		illegal_opcode_i,
	input wire		illegal_address_i,
	input wire		stop_exec_i,
	input wire		mcu_reset_o,
	input wire		stop_permission_o,
	input wire [1:0]	watchdog_timeout_select_o,
	input wire		i2c_location_select_o,
	input wire		pta2_oe_o,
	input wire		pta3_oe_o,
	input wire		ptb6_oe_o,
	input wire		ptb7_oe_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	wire	run = ce_i && !mcu_reset_o;
	sequence rd_of(logic [1:0] s);
		reg_rd_i && ce_i && reg_sel_i == s;
	endsequence
	sequence bad_key;
		run && reg_wr_i && reg_sel_i == 2'h0 && reg_wdata_i != 8'h55 && reg_wdata_i != 8'hAA;
	endsequence
	sequence host_force;
		run && bdm_wr_i && bdm_sel_i == 2'h1 && bdm_wdata_i[0];
	endsequence
	chk_force_reads_zero: assert property (rd_of(2'h1) |=> reg_rdata_o == 8'h00)
		else $error("force register read not zero");
	chk_unmapped_zero: assert property (rd_of(2'h3) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_cause_gaps: assert property (rd_of(2'h0) |=> !reg_rdata_o[2] && !reg_rdata_o[0])
		else $error("cause bits 2 or 0 set");
	chk_debug_reset: assert property (host_force |=> mcu_reset_o)
		else $error("debug force did not reset");
	chk_bad_key: assert property (bad_key ##0 watchdog_timeout_select_o != 2'h0 |-> ##2 mcu_reset_o)
		else $error("bad service value did not reset");
	chk_illegal_opcode_flag_reset: assert property (run && illegal_opcode_i |-> ##[1:3] mcu_reset_o)
		else $error("illegal opcode did not reset");
	chk_illegal_address_flag_reset: assert property (run && illegal_address_i |-> ##[1:3] mcu_reset_o)
		else $error("illegal address did not reset");
	chk_stop_trap: assert property (run && stop_exec_i && !stop_permission_o |-> ##[1:3] mcu_reset_o)
		else $error("forbidden stop did not reset");
	chk_i2c_port_a: assert property (!i2c_location_select_o [*3] |-> !ptb6_oe_o && !ptb7_oe_o)
		else $error("port b driven while i2c on port a");
	chk_i2c_port_b: assert property (i2c_location_select_o [*3] |-> !pta2_oe_o && !pta3_oe_o)
		else $error("port a driven while i2c on port b");
endmodule

bind rstso_top rstso_props u_props (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
	.reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .bdm_wr_i(bdm_wr_i), .bdm_sel_i(bdm_sel_i),
	.bdm_wdata_i(bdm_wdata_i), .illegal_opcode_i(illegal_opcode_i),
	.illegal_address_i(illegal_address_i), .stop_exec_i(stop_exec_i),
	.mcu_reset_o(mcu_reset_o), .stop_permission_o(stop_permission_o),
	.watchdog_timeout_select_o(watchdog_timeout_select_o),
	.i2c_location_select_o(i2c_location_select_o), .pta2_oe_o(pta2_oe_o),
	.pta3_oe_o(pta3_oe_o), .ptb6_oe_o(ptb6_oe_o), .ptb7_oe_o(ptb7_oe_o));

// [bench/rstso_dbg_host.sv]
`timescale 1ns/100ps
module rstso_dbg_host (
	input  wire		clk_sys_i,
	output reg		bdm_wr_o,
	output reg  [1:0]	bdm_sel_o,
	output reg  [7:0]	bdm_wdata_o
);
	initial begin
		bdm_wr_o = 1'b0;
		bdm_sel_o = 2'h0;
		bdm_wdata_o = 8'h00;
	end
	// Background write: one strobe cycle; released lines show inverted data
	task automatic put(input [1:0] sel, input [7:0] data);
		begin
			@(posedge clk_sys_i);
			bdm_wr_o <= 1'b1;
			bdm_sel_o <= sel;
			bdm_wdata_o <= data;
			@(posedge clk_sys_i);
			bdm_wr_o <= 1'b0;
			bdm_sel_o <= ~sel;
			bdm_wdata_o <= ~data;
		end
	endtask
endmodule

// [bench/test_reset_status_system_options.sv]
`timescale 1ns/100ps
module test_reset_status_system_options;
	reg		clk_sys_i = 1'b0;
	reg		reset_n_i = 1'b0;
	reg [1:0]	reg_sel_i = 2'h0;
	reg		reg_wr_i = 1'b0;
	reg		reg_rd_i = 1'b0;
	reg [7:0]	reg_wdata_i = 8'h00;
	reg [5:0]	src = 6'h00;
	reg		pin_reset_n_i = 1'b1;
	reg [31:0]	rnd = 32'h00000000;
	reg		ce_en = 1'b1;
	reg		background_instruction_en = 1'b0;
	reg		wd_clk = 1'b1;
	reg		win = 1'b0;
	reg		pin_hold = 1'b0;
	wire [1:0]	wd_tsel;
	wire		sda_in;
	wire		scl_in;
	wire		pa2;
	wire		pa2_oe;
	wire		pb6;
	wire		pb6_oe;
	reg		rd_seen = 1'b0;
	reg [7:0]	v;
	wire		bdm_wr_i;
	wire [1:0]	bdm_sel_i;
	wire [7:0]	bdm_wdata_i;
	wire [7:0]	reg_rdata_o;
	wire		mcu_reset_o;
	wire		stop_permission_o;
	wire		i2c_location_select_o;
	integer		failures = 0;
	integer		compares = 0;
	integer		i;
	reg [7:0]	exp_q[$];
	localparam [41:0] SRC = {6'h20, 6'h10, 6'h03, 6'h08, 6'h04, 6'h02, 6'h01};
	localparam [55:0] FLG = {8'h02, 8'h40, 8'h18, 8'h10, 8'h10, 8'h08, 8'h10};

	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (!pin_hold) rnd <= $urandom;

	rstso_top #(.WD_BUS_LEN1(19'h00040), .WD_BUS_LEN2(19'h00080), .WD_BUS_LEN3(19'h00100)) u_dut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_en), .reg_sel_i(reg_sel_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .bdm_wr_i(bdm_wr_i), .bdm_sel_i(bdm_sel_i),
		.bdm_wdata_i(bdm_wdata_i), .pin_reset_n_i(pin_reset_n_i), .lvd_trip_i(src[5]),
		.low_voltage_reset_enable_i(src[5]), .illegal_opcode_i(src[0]),
		.illegal_address_i(src[1]), .stop_exec_i(src[2]), .background_instruction_exec_i(src[3]),
		.background_mode_enable_i(background_instruction_en), .watchdog_clock_select_i(wd_clk),
		.watchdog_window_i(win), .wdog_tick_i(rnd[8]), .i2c_sda_drv_i(rnd[0]),
		.i2c_sda_oe_i(rnd[1]), .i2c_scl_drv_i(rnd[2]), .i2c_scl_oe_i(rnd[3]),
		.pta2_i(rnd[4]), .pta3_i(rnd[5]), .ptb6_i(rnd[6]), .ptb7_i(rnd[7]),
		.mcu_reset_o(mcu_reset_o), .stop_permission_o(stop_permission_o),
		.watchdog_timeout_select_o(wd_tsel), .i2c_location_select_o(i2c_location_select_o),
		.i2c_sda_in_o(sda_in), .i2c_scl_in_o(scl_in), .pta2_o(pa2), .pta2_oe_o(pa2_oe),
		.pta3_o(), .pta3_oe_o(), .ptb6_o(pb6), .ptb6_oe_o(pb6_oe), .ptb7_o(), .ptb7_oe_o());
	rstso_dbg_host u_host (.clk_sys_i(clk_sys_i), .bdm_wr_o(bdm_wr_i), .bdm_sel_o(bdm_sel_i),
		.bdm_wdata_o(bdm_wdata_i));

	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic chk8(input [7:0] got, input [7:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task automatic chk1(input got, input exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task automatic end_sim;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task automatic wr(input [1:0] s, input [7:0] d);
		begin
			@(posedge clk_sys_i);
			reg_sel_i <= s;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
			@(posedge clk_sys_i);
			reg_wr_i <= 1'b0;
		end
	endtask
	task automatic rd(input [1:0] s, input [7:0] e);
		begin
			@(posedge clk_sys_i);
			reg_sel_i <= s;
			reg_rd_i <= 1'b1;
			exp_q.push_back(e);
			@(posedge clk_sys_i);
			reg_rd_i <= 1'b0;
		end
	endtask
	// Bounded wait for the reset to start, then to end
	task automatic settle(input integer n);
		integer k;
		begin
			for (k = 0; k < n && mcu_reset_o !== 1'b1; k = k + 1) @(negedge clk_sys_i);
			for (k = 0; k < 200 && mcu_reset_o !== 1'b0; k = k + 1) @(negedge clk_sys_i);
			chk1(mcu_reset_o, 1'b0);
		end
	endtask
	// Pin and supply sources stay active long enough to pass the sync filter
	task automatic fire(input [5:0] s);
		begin
			@(posedge clk_sys_i);
			src <= s;
			pin_reset_n_i <= !s[4];
			@(posedge clk_sys_i);
			src <= s & 6'h20;
			repeat (6) @(posedge clk_sys_i);
			src <= 6'h00;
			pin_reset_n_i <= 1'b1;
		end
	endtask

	always @(posedge clk_sys_i) rd_seen <= reg_rd_i;
	always @(negedge clk_sys_i) if (rd_seen) chk8(reg_rdata_o, exp_q.pop_front());

	initial begin
		#100000;
		failures = failures + 1;
		end_sim;
	end

	initial begin
		v = $urandom(32'h0EEC2D3F);
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		settle(1);
		rd(2'h0, 8'h82);
		rd(2'h1, 8'h00);
		rd(2'h2, 8'hC0);
		rd(2'h3, 8'h00);
		$display("test power_on done");
		v = 8'h60 | ($urandom & 8'h14);
		wr(2'h2, v);
		wr(2'h2, 8'h00);
		rd(2'h2, v);
		wr(2'h1, 8'h01);
		rd(2'h1, 8'h00);
		chk1(i2c_location_select_o, v[2]);
		chk1(stop_permission_o, 1'b1);
		// Freeze the pin pattern long enough to cross the filter and routing flops
		@(posedge clk_sys_i);
		pin_hold <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk1(sda_in, v[2] ? rnd[6] : rnd[4]);
		chk1(scl_in, v[2] ? rnd[7] : rnd[5]);
		chk1(v[2] ? pb6 : pa2, rnd[0]);
		chk1(v[2] ? pb6_oe : pa2_oe, rnd[1]);
		chk1(v[2] ? pa2_oe : pb6_oe, 1'b0);
		chk8({6'h00, wd_tsel}, {6'h00, v[7:6]});
		@(posedge clk_sys_i);
		pin_hold <= 1'b0;
		repeat (4) begin
			wr(2'h0, 8'h55);
			wr(2'h0, 8'hAA);
			repeat (30) @(posedge clk_sys_i);
		end
		chk1(mcu_reset_o, 1'b0);
		rd(2'h0, 8'h82);
		$display("test write_once_service done");
		settle(300);
		rd(2'h0, 8'h20);
		rd(2'h2, 8'hC0);
		wr(2'h2, 8'h40);
		repeat (2) @(posedge clk_sys_i);
		wr(2'h0, $urandom & 8'h3F);
		settle(10);
		rd(2'h0, 8'h20);
		wr(2'h2, 8'h20);
		repeat (2) @(posedge clk_sys_i);
		wr(2'h0, 8'h13);
		repeat (300) @(posedge clk_sys_i);
		chk1(mcu_reset_o, 1'b0);
		$display("test watchdog done");
		for (i = 0; i < 7; i = i + 1) begin
			fire(SRC[i*6 +: 6]);
			settle(10);
			rd(2'h0, FLG[i*8 +: 8]);
		end
		$display("test reset_sources done");
		u_host.put(2'h2, 8'h01);
		repeat (3) @(negedge clk_sys_i);
		chk1(mcu_reset_o, 1'b0);
		u_host.put(2'h1, 8'h01);
		settle(5);
		rd(2'h0, 8'h00);
		repeat (3) @(posedge clk_sys_i);
		$display("test debug_force done");
		@(posedge clk_sys_i);
		ce_en <= 1'b0;
		src <= 6'h01;
		@(posedge clk_sys_i);
		ce_en <= 1'b1;
		background_instruction_en <= 1'b1;
		src <= 6'h08;
		@(posedge clk_sys_i);
		src <= 6'h00;
		repeat (3) @(negedge clk_sys_i);
		chk1(mcu_reset_o, 1'b0);
		$display("test enable_gates done");
		wr(2'h2, 8'h40);
		wr(2'h0, 8'h55);
		wr(2'h0, 8'hAA);
		@(posedge clk_sys_i);
		win <= 1'b1;
		// Late service lands past 75% of the 64-cycle period
		repeat (50) @(posedge clk_sys_i);
		wr(2'h0, 8'h55);
		wr(2'h0, 8'hAA);
		repeat (3) @(negedge clk_sys_i);
		chk1(mcu_reset_o, 1'b0);
		wr(2'h0, 8'h55);
		settle(10);
		rd(2'h0, 8'h20);
		$display("test window done");
		@(posedge clk_sys_i);
		wd_clk <= 1'b0;
		win <= 1'b0;
		wr(2'h2, 8'h40);
		settle(300);
		rd(2'h0, 8'h20);
		$display("test tick_clock done");
		end_sim;
	end
endmodule
